// ===== inc/eivs_pkg.sv
package eivs_pkg;
	// Register offsets on the plain register port.
	localparam logic [7:0] OFF_EXT_IRQ_ENABLE   = 8'h1D;
	localparam logic [7:0] OFF_CORE_CONTROL     = 8'h35;
	localparam logic [7:0] OFF_EXT_IRQ_SENSE    = 8'h69;
	localparam logic [7:0] OFF_EXT_IRQ_FLAGS    = 8'h1C;
	localparam logic [7:0] OFF_CHANGE_CTRL      = 8'h68;
	localparam logic [7:0] OFF_CHANGE_FLAGS     = 8'h1B;
	localparam logic [7:0] OFF_CHANGE_MASK_0    = 8'h6B;
	localparam logic [7:0] OFF_CHANGE_MASK_1    = 8'h6C;
	localparam logic [7:0] OFF_CHANGE_MASK_2    = 8'h6D;
	localparam logic [7:0] RESET_BYTE           = 8'h00;
	// Field positions.
	localparam int BIT_UNLOCK    = 0;
	localparam int BIT_VSEL      = 1;
	localparam int BIT_PULLUP    = 4;
	// Widths of the live fields, the rest reads as zero.
	localparam logic [7:0] MASK_EXT_ENABLE = 8'h03;
	localparam logic [7:0] MASK_SENSE      = 8'h0F;
	localparam logic [7:0] MASK_CORE_CTRL  = 8'h13;
	localparam logic [7:0] MASK_GROUPS     = 8'h07;
	localparam logic [7:0] MASK_GROUP_1    = 8'h7F;
	// Sense encodings.
	localparam logic [1:0] SENSE_LOW  = 2'h0;
	localparam logic [1:0] SENSE_ANY  = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;
	// Unlock window in cycles.
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
	typedef enum logic [1:0] {
		EIVS_IDLE  = 2'b00,
		EIVS_OPEN  = 2'b01,
		EIVS_GUARD = 2'b11
	} eivs_state_e;
endpackage : eivs_pkg

// ===== design/eivs_top.sv
// Operation
// - Select bit picks flash start or boot
// - Block interrupts during the unlock sequence
// - Global enable bit left untouched by block
// - Unlock clears after four cycles or write
// - Boot vectors plus app lock: app masked
// - App vectors plus boot lock: boot masked
// - Pins trigger even when driven as outputs
// - Three change groups over their pin ranges
// - Mask registers pick contributing change pins
// - Pin change detected without the clock; here the pins pass through clocked sampling stages
// - Level mode requests while pin is low
// - Edges need clock, low level does not; here the low level is also read from the clocked sample
// - Short wake level gives no interrupt
// - Two-bit sense field per request pin
// - Sample pin before edge detection
// - Request needs own enable and global enable
// - Unused bits read as zero
// - Request flag set, cleared by entry or one
// - Group needs enable and global, flag clearing
module eivs_top (
	input  wire logic        REF_CLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [7:0]  RDATA_O,
	input  wire logic        REQ_PIN_A_I,
	input  wire logic        REQ_PIN_B_I,
	input  wire logic [23:0] CHANGE_WATCH_PINS_I,
	input  wire logic        GLOBAL_IRQ_EN_I,
	input  wire logic        EXEC_IN_BOOT_I,
	input  wire logic        APP_LOCK_BIT_I,
	input  wire logic        BOOT_LOCK_BIT_I,
	input  wire logic        WAKE_DONE_I,
	input  wire logic [4:0]  IRQ_ACK_I,
	output logic      [4:0]  IRQ_TAKE_O,
	output logic             VECTOR_TABLE_SELECT_O,
	output logic             PULLUP_DISABLE_O,
	output logic             IRQ_BLOCKED_O
);
	logic [1:0]  sync_a_reg, sync_b_reg;
	logic        prev_a_reg, prev_b_reg;
	logic [23:0] cw_s1_reg, cw_s2_reg, cw_prev_reg;
	logic [7:0]  enable_reg, sense_reg, core_reg, grp_ctrl_reg;
	logic [7:0]  mask0_reg, mask1_reg, mask2_reg;
	logic [1:0]  eflag_reg, eflag_next;
	logic [2:0]  gflag_reg, gflag_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic        tail_reg;
	eivs_pkg::eivs_state_e state_reg, state_next;
	logic [7:0]  rdata_reg, rd_mux;

	// Edge detect on the synchronised level; the first stage only feeds the second.
	function automatic logic trig(input logic [1:0] s, input logic cur,
		input logic prv);
		case (s)
			eivs_pkg::SENSE_ANY:  trig = cur ^ prv;
			eivs_pkg::SENSE_FALL: trig = prv & ~cur;
			eivs_pkg::SENSE_RISE: trig = cur & ~prv;
			default:              trig = 1'b0;
		endcase
	endfunction

	wire logic wr_core = WR_I && ADDR_I == eivs_pkg::OFF_CORE_CONTROL;
	wire logic wr_en   = WR_I && ADDR_I == eivs_pkg::OFF_EXT_IRQ_ENABLE;
	wire logic wr_sns  = WR_I && ADDR_I == eivs_pkg::OFF_EXT_IRQ_SENSE;
	wire logic wr_ef   = WR_I && ADDR_I == eivs_pkg::OFF_EXT_IRQ_FLAGS;
	wire logic wr_gc   = WR_I && ADDR_I == eivs_pkg::OFF_CHANGE_CTRL;
	wire logic wr_gf   = WR_I && ADDR_I == eivs_pkg::OFF_CHANGE_FLAGS;
	wire logic wr_m0   = WR_I && ADDR_I == eivs_pkg::OFF_CHANGE_MASK_0;
	wire logic wr_m1   = WR_I && ADDR_I == eivs_pkg::OFF_CHANGE_MASK_1;
	wire logic wr_m2   = WR_I && ADDR_I == eivs_pkg::OFF_CHANGE_MASK_2;

	wire logic pin_a = sync_a_reg[1];
	wire logic pin_b = sync_b_reg[1];
	wire logic [1:0] sns_a = sense_reg[1:0];
	wire logic [1:0] sns_b = sense_reg[3:2];
	wire logic lvl_a = sns_a == eivs_pkg::SENSE_LOW;
	wire logic lvl_b = sns_b == eivs_pkg::SENSE_LOW;
	// Pins are sensed from the pad whatever their direction.
	wire logic hit_a = trig(sns_a, pin_a, prev_a_reg);
	wire logic hit_b = trig(sns_b, pin_b, prev_b_reg);
	// Level request is live; a level gone before wake-up never asks.
	wire logic lv_a = lvl_a & ~pin_a & WAKE_DONE_I;
	wire logic lv_b = lvl_b & ~pin_b & WAKE_DONE_I;

	wire logic [23:0] cw_diff = cw_s2_reg ^ cw_prev_reg;
	wire logic [2:0] grp_hit = {
		|(cw_diff[23:16] & mask2_reg),
		|(cw_diff[14:8] & mask1_reg[6:0]),
		|(cw_diff[7:0] & mask0_reg)};

	wire logic vsel = core_reg[eivs_pkg::BIT_VSEL];
	wire logic unlock = core_reg[eivs_pkg::BIT_UNLOCK];
	wire logic seq_block = state_reg != eivs_pkg::EIVS_IDLE;
	wire logic sect_block = (vsel & APP_LOCK_BIT_I & ~EXEC_IN_BOOT_I)
		| (~vsel & BOOT_LOCK_BIT_I & EXEC_IN_BOOT_I);
	// The global enable is only read, never written here.
	wire logic allow = GLOBAL_IRQ_EN_I & ~seq_block & ~sect_block;
	wire logic [1:0] ext_pend = {eflag_reg[1] | lv_b, eflag_reg[0] | lv_a};
	wire logic [1:0] ext_go = ext_pend & enable_reg[1:0] & {2{allow}};
	wire logic [2:0] grp_go = gflag_reg & grp_ctrl_reg[2:0] & {3{allow}};

	assign IRQ_TAKE_O = {grp_go, ext_go};
	assign VECTOR_TABLE_SELECT_O = vsel;
	assign PULLUP_DISABLE_O = core_reg[eivs_pkg::BIT_PULLUP];
	assign IRQ_BLOCKED_O = seq_block | sect_block;
	assign RDATA_O = rdata_reg;

	// Flags: a new event wins over a clear in the same cycle.
	always_comb begin
		eflag_next = eflag_reg & ~(IRQ_ACK_I[1:0] | (wr_ef ? WDATA_I[1:0] : 2'h0));
		eflag_next = eflag_next | {hit_b, hit_a};
		if (lvl_a) begin
			eflag_next[0] = 1'b0;
		end
		if (lvl_b) begin
			eflag_next[1] = 1'b0;
		end
		gflag_next = (gflag_reg & ~(IRQ_ACK_I[4:2]
			| (wr_gf ? WDATA_I[2:0] : 3'h0))) | grp_hit;
	end

	// Unlock window: OPEN counts four cycles; a select write moves to
	// GUARD, which holds the block one more instruction cycle.
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			eivs_pkg::EIVS_IDLE: begin
				if (wr_core && WDATA_I[eivs_pkg::BIT_UNLOCK]) begin
					state_next = eivs_pkg::EIVS_OPEN;
					// The count starts full so the window spans four
					// whole cycles after the set cycle.
					cnt_next = eivs_pkg::UNLOCK_CYCLES;
				end
			end
			eivs_pkg::EIVS_OPEN: begin
				if (wr_core && !WDATA_I[eivs_pkg::BIT_UNLOCK]) begin
					state_next = eivs_pkg::EIVS_GUARD;
				end else if (cnt_reg == 3'h1) begin
					state_next = eivs_pkg::EIVS_IDLE;
				end else begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
			eivs_pkg::EIVS_GUARD: begin
				state_next = eivs_pkg::EIVS_IDLE;
			end
			default: begin
				state_next = eivs_pkg::EIVS_IDLE;
			end
		endcase
	end

	always_comb begin
		case (ADDR_I)
			eivs_pkg::OFF_EXT_IRQ_ENABLE: rd_mux = enable_reg;
			eivs_pkg::OFF_CORE_CONTROL:   rd_mux = core_reg;
			eivs_pkg::OFF_EXT_IRQ_SENSE:  rd_mux = sense_reg;
			eivs_pkg::OFF_EXT_IRQ_FLAGS:  rd_mux = {6'h00, eflag_reg};
			eivs_pkg::OFF_CHANGE_CTRL:    rd_mux = grp_ctrl_reg;
			eivs_pkg::OFF_CHANGE_FLAGS:   rd_mux = {5'h00, gflag_reg};
			eivs_pkg::OFF_CHANGE_MASK_0:  rd_mux = mask0_reg;
			eivs_pkg::OFF_CHANGE_MASK_1:  rd_mux = mask1_reg;
			eivs_pkg::OFF_CHANGE_MASK_2:  rd_mux = mask2_reg;
			default:                      rd_mux = eivs_pkg::RESET_BYTE;
		endcase
	end

	// Sampling clocked; the pads are outside the clock domain.
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			sync_a_reg <= 2'h3;
			sync_b_reg <= 2'h3;
			prev_a_reg <= 1'b1;
			prev_b_reg <= 1'b1;
			cw_s1_reg <= 24'h000000;
			cw_s2_reg <= 24'h000000;
			cw_prev_reg <= 24'h000000;
		end else begin
			sync_a_reg <= {sync_a_reg[0], REQ_PIN_A_I};
			sync_b_reg <= {sync_b_reg[0], REQ_PIN_B_I};
			prev_a_reg <= pin_a;
			prev_b_reg <= pin_b;
			// A sleep-time change needs an asynchronous latch in the pad
			// ring; here the same masks gate the synchronous copy.
			cw_s1_reg <= CHANGE_WATCH_PINS_I;
			cw_s2_reg <= cw_s1_reg;
			cw_prev_reg <= cw_s2_reg;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			enable_reg <= eivs_pkg::RESET_BYTE;
			sense_reg <= eivs_pkg::RESET_BYTE;
			grp_ctrl_reg <= eivs_pkg::RESET_BYTE;
			mask0_reg <= eivs_pkg::RESET_BYTE;
			mask1_reg <= eivs_pkg::RESET_BYTE;
			mask2_reg <= eivs_pkg::RESET_BYTE;
			eflag_reg <= 2'h0;
			gflag_reg <= 3'h0;
			rdata_reg <= eivs_pkg::RESET_BYTE;
		end else begin
			if (wr_en) begin
				enable_reg <= WDATA_I & eivs_pkg::MASK_EXT_ENABLE;
			end
			if (wr_sns) begin
				sense_reg <= WDATA_I & eivs_pkg::MASK_SENSE;
			end
			if (wr_gc) begin
				grp_ctrl_reg <= WDATA_I & eivs_pkg::MASK_GROUPS;
			end
			if (wr_m0) begin
				mask0_reg <= WDATA_I;
			end
			if (wr_m1) begin
				mask1_reg <= WDATA_I & eivs_pkg::MASK_GROUP_1;
			end
			if (wr_m2) begin
				mask2_reg <= WDATA_I;
			end
			eflag_reg <= eflag_next;
			gflag_reg <= gflag_next;
			rdata_reg <= RD_I ? rd_mux : eivs_pkg::RESET_BYTE;
		end
	end

	// Select changes only inside the window; unlock mirrors the state.
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			core_reg <= eivs_pkg::RESET_BYTE;
			state_reg <= eivs_pkg::EIVS_IDLE;
			cnt_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (wr_core) begin
				core_reg[eivs_pkg::BIT_PULLUP] <= WDATA_I[eivs_pkg::BIT_PULLUP];
			end
			if (wr_core && state_reg == eivs_pkg::EIVS_OPEN
				&& !WDATA_I[eivs_pkg::BIT_UNLOCK]) begin
				core_reg[eivs_pkg::BIT_VSEL] <= WDATA_I[eivs_pkg::BIT_VSEL];
			end
			core_reg[eivs_pkg::BIT_UNLOCK] <=
				state_next == eivs_pkg::EIVS_OPEN;
		end
	end

	logic [3:0] open_len_reg;
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			open_len_reg <= 4'h0;
		end else begin
			open_len_reg <= unlock ? open_len_reg + 4'h1 : 4'h0;
		end
	end

	AST_UNLOCK_MAX: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		open_len_reg <= 4'h4)
		else $error("Unlock stayed set beyond four cycles.");
	AST_UNLOCK_BLOCKS: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		unlock |-> IRQ_TAKE_O == 5'h00)
		else $error("Interrupt taken while unlocked.");
	AST_SEL_STEADY: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		$past(state_reg) != eivs_pkg::EIVS_OPEN |-> $stable(vsel))
		else $error("Vector select changed without unlock.");
	AST_GLOBAL: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		!GLOBAL_IRQ_EN_I |-> IRQ_TAKE_O == 5'h00)
		else $error("Interrupt taken with global enable off.");
	AST_LEVEL: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		lvl_a |=> !eflag_reg[0])
		else $error("Flag set in level mode.");
	AST_RISE: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		sns_a == eivs_pkg::SENSE_RISE && $rose(pin_a) && !$past(sense_reg[1:0]
		== eivs_pkg::SENSE_LOW) |=> eflag_reg[0])
		else $error("Rising edge lost.");
	AST_APPLOCK: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		vsel && APP_LOCK_BIT_I && !EXEC_IN_BOOT_I |-> IRQ_TAKE_O == 5'h00)
		else $error("Interrupt taken from locked application.");
	AST_BOOTLOCK: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		!vsel && BOOT_LOCK_BIT_I && EXEC_IN_BOOT_I |-> IRQ_TAKE_O == 5'h00)
		else $error("Interrupt taken from locked boot section.");
	AST_RSVD: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
		enable_reg[7:2] == 6'h00 && sense_reg[7:4] == 4'h0)
		else $error("Reserved bits set.");

	AST_GUARD_ONE: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		state_reg == eivs_pkg::EIVS_GUARD |=> state_reg == eivs_pkg::EIVS_IDLE)
		else $error("Guard cycle lasted too long.");

	AST_UNLOCK_OUT: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		unlock |-> IRQ_BLOCKED_O)
		else $error("Unlock window not shown as blocked.");

	AST_OPEN_FULL: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		$rose(unlock) && !wr_core |=> unlock)
		else $error("Unlock window closed too early.");

	AST_UNLOCK_CLEAR: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		unlock && wr_core && !WDATA_I[eivs_pkg::BIT_UNLOCK] |=> !unlock)
		else $error("Unlock kept after select write.");

	AST_GUARD_LOCKED: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		state_reg == eivs_pkg::EIVS_GUARD |-> !unlock)
		else $error("Unlock shown during guard cycle.");

	AST_SECT_OUT: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		sect_block |-> IRQ_BLOCKED_O)
		else $error("Section lock not shown as blocked.");

	AST_EXT_EN_A: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		!enable_reg[0] |-> !IRQ_TAKE_O[0])
		else $error("Request a taken while disabled.");

	AST_EXT_EN_B: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		!enable_reg[1] |-> !IRQ_TAKE_O[1])
		else $error("Request b taken while disabled.");

	AST_GRP_EN: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		grp_ctrl_reg[2:0] == 3'h0 |-> IRQ_TAKE_O[4:2] == 3'h0)
		else $error("Change group taken while disabled.");

	AST_SET_WINS: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		hit_a && !lvl_a |=> eflag_reg[0])
		else $error("Edge lost against a clear.");

	AST_ACK_CLEAR: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		IRQ_ACK_I[0] && !hit_a |=> !eflag_reg[0])
		else $error("Flag a kept after handler entry.");

	AST_LEVEL_LIVE: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		lv_a && enable_reg[0] && allow |-> IRQ_TAKE_O[0])
		else $error("Low level not requesting.");

	AST_WAKE_GATE: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		lvl_a && !WAKE_DONE_I && !eflag_reg[0] |-> !IRQ_TAKE_O[0])
		else $error("Level request before wake-up ended.");

	AST_GRP_SET: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		grp_hit[2] |=> gflag_reg[2])
		else $error("Group 2 change lost.");

	AST_GRP_ACK: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		IRQ_ACK_I[2] && !grp_hit[0] |=> !gflag_reg[0])
		else $error("Group 0 flag kept after handler entry.");

	AST_MASK1_TOP: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		mask1_reg[7] == 1'b0)
		else $error("Unused mask bit of group 1 set.");

	AST_FALL_B: assert property (@(posedge REF_CLK_I)
		disable iff (!ARST_N_I)
		sns_b == eivs_pkg::SENSE_FALL && $fell(pin_b)
		&& $past(sns_b) == eivs_pkg::SENSE_FALL |=> eflag_reg[1])
		else $error("Falling edge on b lost.");
endmodule // eivs_top

// ===== verif/eivs_core_model.sv
module eivs_core_model (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       accept_i,
	input  wire logic [4:0] take_i,
	output logic      [4:0] ack_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// The core enters one handler at a time, lowest request first.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ack_o <= 5'h00;
		else if (accept_i && take_i != 5'h00 && ack_o == 5'h00)
			ack_o <= take_i & (~take_i + 5'h01);
		else
			ack_o <= 5'h00;
	end
endmodule // eivs_core_model

// ===== verif/ext_irq_and_vector_select_bench.sv
module ext_irq_and_vector_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        arst_n;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr_s;
	logic        rd_s;
	logic [7:0]  rdata;
	logic [1:0]  pin;
	logic [23:0] cw;
	logic        gie;
	logic        in_boot;
	logic        app_lock;
	logic        boot_lock;
	logic        wake;
	logic        accept;
	logic [4:0]  ack;
	logic [4:0]  take;
	logic        vsel;
	logic        blocked;
	logic        pud;
	logic [23:0] msk;
	int          idx;
	int          seed = 32'h52951C62;
	int          bad_count = 0;
	int          samples_checked = 0;

	eivs_top u_dut (
		.REF_CLK_I            (clk),
		.ARST_N_I             (arst_n),
		.ADDR_I               (addr),
		.WDATA_I              (wdata),
		.WR_I                 (wr_s),
		.RD_I                 (rd_s),
		.RDATA_O              (rdata),
		.REQ_PIN_A_I          (pin[0]),
		.REQ_PIN_B_I          (pin[1]),
		.CHANGE_WATCH_PINS_I  (cw),
		.GLOBAL_IRQ_EN_I      (gie),
		.EXEC_IN_BOOT_I       (in_boot),
		.APP_LOCK_BIT_I       (app_lock),
		.BOOT_LOCK_BIT_I      (boot_lock),
		.WAKE_DONE_I          (wake),
		.IRQ_ACK_I            (ack),
		.IRQ_TAKE_O           (take),
		.VECTOR_TABLE_SELECT_O(vsel),
		.PULLUP_DISABLE_O     (pud),
		.IRQ_BLOCKED_O        (blocked)
	);

	eivs_core_model u_core (
		.clk_i   (clk),
		.arst_n_i(arst_n),
		.accept_i(accept),
		.take_i  (take),
		.ack_o   (ack)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Read data is only valid in the cycle after the strobe is taken.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 check(rdata, exp);
	endtask

	task automatic lk(input logic a, input logic b, input logic e,
			input logic exp);
		@(posedge clk);
		app_lock <= a;
		boot_lock <= b;
		in_boot <= e;
		#1 check({7'h00, blocked}, {7'h00, exp});
	endtask

	function automatic logic edge_hit(input logic [1:0] m, input logic v);
		return m == eivs_pkg::SENSE_ANY ||
			(m == eivs_pkg::SENSE_FALL && !v) ||
			(m == eivs_pkg::SENSE_RISE && v);
	endfunction

	// Pin 15 has no mask bit, so it can never raise group 1.
	function automatic logic [4:0] grp_exp(input logic [23:0] m, input int i);
		if (i == 15 || !m[i])
			return 5'h00;
		return 5'h04 << (i / 8);
	endfunction

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		arst_n <= 1'b0;
		{addr, wdata, wr_s, rd_s, cw, in_boot, app_lock, boot_lock} <= '0;
		{accept, pin, gie, wake} <= 5'h0F;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		rd(eivs_pkg::OFF_CORE_CONTROL, 8'h00);
		wr(eivs_pkg::OFF_EXT_IRQ_ENABLE, 8'hFF);
		rd(eivs_pkg::OFF_EXT_IRQ_ENABLE, 8'h03);
		wr(eivs_pkg::OFF_EXT_IRQ_SENSE, 8'hFF);
		rd(eivs_pkg::OFF_EXT_IRQ_SENSE, 8'h0F);
		rd(8'h00, 8'h00);
		wr(eivs_pkg::OFF_CORE_CONTROL, 8'h01);
		#1 check({7'h00, blocked}, 8'h01);
		wr(eivs_pkg::OFF_CORE_CONTROL, 8'h02);
		#1 check({6'h00, vsel, blocked}, 8'h03);
		tick(2);
		check({7'h00, blocked}, 8'h00);
		rd(eivs_pkg::OFF_CORE_CONTROL, 8'h02);
		wr(eivs_pkg::OFF_CORE_CONTROL, 8'h03);
		tick(3);
		check({7'h00, blocked}, 8'h01);
		tick(1);
		check({7'h00, blocked}, 8'h00);
		rd(eivs_pkg::OFF_CORE_CONTROL, 8'h02);
		wr(eivs_pkg::OFF_CORE_CONTROL, 8'h00);
		#1 check({7'h00, vsel}, 8'h01);
		lk(1'b1, 1'b0, 1'b0, 1'b1);
		lk(1'b1, 1'b0, 1'b1, 1'b0);
		wr(eivs_pkg::OFF_CORE_CONTROL, 8'h01);
		wr(eivs_pkg::OFF_CORE_CONTROL, 8'h00);
		tick(2);
		check({7'h00, vsel}, 8'h00);
		lk(1'b0, 1'b1, 1'b1, 1'b1);
		lk(1'b0, 1'b1, 1'b0, 1'b0);
		wr(eivs_pkg::OFF_CORE_CONTROL, 8'h10);
		#1 check({7'h00, pud}, 8'h01);
		rd(eivs_pkg::OFF_CORE_CONTROL, 8'h10);
		for (int p = 0; p < 2; p++) begin
			for (int m = 1; m < 4; m++) begin
				wr(eivs_pkg::OFF_EXT_IRQ_SENSE, 8'(m) << (2 * p));
				wr(eivs_pkg::OFF_EXT_IRQ_FLAGS, 8'h03);
				for (int v = 0; v < 2; v++) begin
					@(posedge clk);
					pin[p] <= 1'(v);
					tick(4);
					check({3'h0, take}, 8'(edge_hit(2'(m), 1'(v))) << p);
					wr(eivs_pkg::OFF_EXT_IRQ_FLAGS, 8'h03);
				end
			end
		end
		wr(eivs_pkg::OFF_EXT_IRQ_SENSE, 8'h00);
		wr(eivs_pkg::OFF_EXT_IRQ_ENABLE, 8'h01);
		@(posedge clk);
		pin[0] <= 1'b0;
		tick(4);
		check({3'h0, take}, 8'h01);
		rd(eivs_pkg::OFF_EXT_IRQ_FLAGS, 8'h00);
		@(posedge clk);
		gie <= 1'b0;
		tick(2);
		check({3'h0, take}, 8'h00);
		@(posedge clk);
		gie <= 1'b1;
		wake <= 1'b0;
		tick(2);
		check({3'h0, take}, 8'h00);
		@(posedge clk);
		wake <= 1'b1;
		wr(eivs_pkg::OFF_EXT_IRQ_ENABLE, 8'h00);
		#1 check({3'h0, take}, 8'h00);
		wr(eivs_pkg::OFF_CHANGE_CTRL, 8'h07);
		for (int i = 0; i < 10; i++) begin
			msk = (i == 0) ? 24'hFFFFFF : 24'($random(seed));
			idx = (i == 0) ? 15 : {$random(seed)} % 24;
			wr(eivs_pkg::OFF_CHANGE_MASK_0, msk[7:0]);
			wr(eivs_pkg::OFF_CHANGE_MASK_1, msk[15:8]);
			wr(eivs_pkg::OFF_CHANGE_MASK_2, msk[23:16]);
			@(posedge clk);
			cw[idx] <= ~cw[idx];
			tick(1);
			check({3'h0, take}, 8'h00);
			tick(3);
			check({3'h0, take}, {3'h0, grp_exp(msk, idx)});
			accept <= 1'b1;
			tick(3);
			check({3'h0, take}, 8'h00);
			accept <= 1'b0;
		end
		report_and_stop();
	end
endmodule // ext_irq_and_vector_select_bench
